// ### rtl/sbc_pkg.sv
package sbc_pkg;

   // ==========================================
   // Register offsets
   localparam logic [6:0] comparator12_threshold_addr = 7'h0f;
   localparam logic [6:0] comparator3_threshold_and_calibration_addr = 7'h10;
   localparam logic [6:0] mux_deadtime_unlock_control_addr = 7'h11;
   localparam logic [6:0] locked_sense_control_addr = 7'h12;

   // ==========================================
   // Reset values
   localparam logic [7:0] comparator12_threshold_rst = 8'h88;
   localparam logic [7:0] comparator3_threshold_and_calibration_rst = 8'h80;
   localparam logic [7:0] mux_deadtime_unlock_control_rst = 8'h00;
   localparam logic [7:0] locked_sense_control_rst = 8'h40;

   // ==========================================
   // Field positions
   localparam int comp_one_code_lsb = 4;
   localparam int comp_two_code_lsb = 0;
   localparam int comp_three_code_lsb = 4;
   localparam int cal_connect_bit = 3;
   localparam int amp_one_cal_bit = 2;
   localparam int amp_two_cal_bit = 1;
   localparam int amp_three_cal_bit = 0;
   localparam int deadtime_disable_bit = 7;
   localparam int unlock_bit = 5;
   localparam int mux_sel_lsb = 0;
   localparam int offset_source_bit = 6;
   localparam int override_bit = 0;

   // Calibration done inputs, one per amplifier and one for back-emf
   localparam int done_amp_one = 0;
   localparam int done_amp_two = 1;
   localparam int done_amp_three = 2;
   localparam int done_backemf = 3;

   // ==========================================
   // Serial frame timing, counted in link clock edges
   localparam logic [4:0] frame_cmd_last = 5'h07;
   localparam logic [4:0] frame_wr_last = 5'h0f;
   localparam logic [4:0] frame_rd_first = 5'h10;

   // Mux select codes
   localparam logic [2:0] mux_gnd = 3'h0;
   localparam logic [2:0] mux_temp = 3'h2;
   localparam logic [2:0] mux_amp3_res = 3'h4;
   localparam logic [2:0] mux_amp1 = 3'h5;
   localparam logic [2:0] mux_amp2 = 3'h6;
   localparam logic [2:0] mux_amp3_direct = 3'h7;

   typedef struct packed {
      logic comp_one_enable;
      logic [3:0] comp_one_threshold_code;
      logic comp_two_enable;
      logic [3:0] comp_two_threshold_code;
      logic comp_three_enable;
      logic [3:0] comp_three_threshold_code;
   } sbc_comparator_t;

   typedef struct packed {
      logic calibration_input_connect;
      logic amp_one_calibrate;
      logic amp_two_calibrate;
      logic amp_three_calibrate;
      logic backemf_calibrate;
   } sbc_calibration_t;

   typedef struct packed {
      logic gnd_pulldown;
      logic temp_monitor;
      logic amp_one;
      logic amp_two;
      logic amp_three_series_res;
      logic amp_three_direct;
      logic backemf_series_res;
      logic backemf_direct;
   } sbc_mux_route_t;

endpackage

// ### rtl/sbc_sense_block_control_regs.sv
`timescale 1ns/1ns
`default_nettype none

module sbc_sense_block_control_regs (
   input wire logic clock,
   input wire logic reset,
   input wire logic link_sclk,
   input wire logic link_cs_n,
   input wire logic link_mosi,
   output logic link_miso,
   input wire logic backemf_sensing_enable,
   input wire logic [3:0] calibration_done,
   output sbc_pkg::sbc_comparator_t comparator_cfg,
   output sbc_pkg::sbc_calibration_t calibration_cfg,
   output logic adaptive_deadtime_disable,
   output sbc_pkg::sbc_mux_route_t mux_route,
   output logic backemf_offset_source,
   output logic gate_override_enable
);

   // ==========================================
   // Link side, clocked by the serial clock
   logic [4:0] bit_cnt_reg;
   logic [14:0] rx_shift_reg;
   logic frame_read_reg;
   logic [6:0] wr_addr_hold_reg;
   logic [7:0] wr_data_hold_reg;
   logic wr_toggle_reg;
   logic [6:0] rd_addr_hold_reg;
   logic rd_req_toggle_reg;
   logic rd_ack_s1_reg;
   logic rd_ack_s2_reg;
   logic rd_ack_seen_reg;
   logic [7:0] tx_shift_reg;
   logic miso_reg;

   // System side
   logic wr_s1_reg, wr_s2_reg, wr_prev_reg;
   logic rq_s1_reg, rq_s2_reg, rq_prev_reg;
   logic [7:0] rd_data_hold_reg;
   logic rd_ack_toggle_reg;
   logic bemf_s1_reg, bemf_s2_reg;
   logic [3:0] done_s1_reg, done_s2_reg, done_prev_reg;
   logic [7:0] comp12_reg;
   logic [7:0] cal_reg;
   logic [7:0] mux_reg;
   logic [7:0] locked_reg;
   logic cal3_is_bemf_reg;

   logic wr_pulse, rd_pulse;
   logic [3:0] done_edge;
   logic cal3_done;
   logic [7:0] rd_mux;

   // Bit counter, cleared whenever the frame select is idle
   always_ff @(posedge link_sclk or posedge link_cs_n) begin
      if (link_cs_n) begin
         bit_cnt_reg <= 5'h00;
      end else if (bit_cnt_reg != 5'h1f) begin
         bit_cnt_reg <= bit_cnt_reg + 5'h01;
      end
   end

   // Receive shift, MSB first
   always_ff @(posedge link_sclk) begin
      rx_shift_reg <= {rx_shift_reg[13:0], link_mosi};
   end

   // Command byte decode and write capture
   always_ff @(posedge link_sclk or posedge reset) begin
      if (reset) begin
         frame_read_reg <= 1'b0;
         wr_addr_hold_reg <= 7'h00;
         wr_data_hold_reg <= 8'h00;
         wr_toggle_reg <= 1'b0;
         rd_addr_hold_reg <= 7'h00;
         rd_req_toggle_reg <= 1'b0;
      end else if (!link_cs_n) begin
         if (bit_cnt_reg == sbc_pkg::frame_cmd_last) begin
            frame_read_reg <= rx_shift_reg[6];
            if (rx_shift_reg[6]) begin
               rd_addr_hold_reg <= {rx_shift_reg[5:0], link_mosi};
               rd_req_toggle_reg <= ~rd_req_toggle_reg;
            end
         end else if (bit_cnt_reg == sbc_pkg::frame_wr_last && !frame_read_reg) begin
            wr_addr_hold_reg <= rx_shift_reg[13:7];
            wr_data_hold_reg <= {rx_shift_reg[6:0], link_mosi};
            wr_toggle_reg <= ~wr_toggle_reg;
         end
      end
   end

   // Read answer crossing back and transmit shift
   always_ff @(posedge link_sclk or posedge reset) begin
      if (reset) begin
         rd_ack_s1_reg <= 1'b0;
         rd_ack_s2_reg <= 1'b0;
         rd_ack_seen_reg <= 1'b0;
         tx_shift_reg <= 8'h00;
      end else begin
         rd_ack_s1_reg <= rd_ack_toggle_reg;
         rd_ack_s2_reg <= rd_ack_s1_reg;
         if (bit_cnt_reg == sbc_pkg::frame_wr_last && frame_read_reg) begin
            rd_ack_seen_reg <= rd_ack_s2_reg;
            tx_shift_reg <= (rd_ack_s2_reg != rd_ack_seen_reg) ? rd_data_hold_reg : 8'h00;
         end else if (bit_cnt_reg >= sbc_pkg::frame_rd_first) begin
            tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
         end
      end
   end

   // Data out changes on the falling edge
   always_ff @(negedge link_sclk or posedge reset) begin
      if (reset) begin
         miso_reg <= 1'b0;
      end else begin
         miso_reg <= frame_read_reg && !link_cs_n && (bit_cnt_reg >= sbc_pkg::frame_rd_first)
                     && tx_shift_reg[7];
      end
   end

   assign link_miso = miso_reg;

   // ==========================================
   // Crossings into the system clock
   always_ff @(posedge clock) begin
      if (reset) begin
         wr_s1_reg <= 1'b0;
         wr_s2_reg <= 1'b0;
         wr_prev_reg <= 1'b0;
         rq_s1_reg <= 1'b0;
         rq_s2_reg <= 1'b0;
         rq_prev_reg <= 1'b0;
         bemf_s1_reg <= 1'b0;
         bemf_s2_reg <= 1'b0;
         done_s1_reg <= 4'h0;
         done_s2_reg <= 4'h0;
         done_prev_reg <= 4'h0;
      end else begin
         wr_s1_reg <= wr_toggle_reg;
         wr_s2_reg <= wr_s1_reg;
         wr_prev_reg <= wr_s2_reg;
         rq_s1_reg <= rd_req_toggle_reg;
         rq_s2_reg <= rq_s1_reg;
         rq_prev_reg <= rq_s2_reg;
         bemf_s1_reg <= backemf_sensing_enable;
         bemf_s2_reg <= bemf_s1_reg;
         done_s1_reg <= calibration_done;
         done_s2_reg <= done_s1_reg;
         done_prev_reg <= done_s2_reg;
      end
   end

   // Event pulses
   assign wr_pulse = wr_s2_reg ^ wr_prev_reg;
   assign rd_pulse = rq_s2_reg ^ rq_prev_reg;
   assign done_edge = done_s2_reg & ~done_prev_reg;
   assign cal3_done = cal3_is_bemf_reg ? done_edge[sbc_pkg::done_backemf]
                                       : done_edge[sbc_pkg::done_amp_three];

   // ==========================================
   // Register writes
   // comparator codes stored
   always_ff @(posedge clock) begin
      if (reset) begin
         comp12_reg <= sbc_pkg::comparator12_threshold_rst;
      end else if (wr_pulse && wr_addr_hold_reg == sbc_pkg::comparator12_threshold_addr) begin
         comp12_reg <= wr_data_hold_reg;
      end
   end

   // requests held until done, set wins
   always_ff @(posedge clock) begin
      if (reset) begin
         cal_reg <= sbc_pkg::comparator3_threshold_and_calibration_rst;
         cal3_is_bemf_reg <= 1'b0;
      end else begin
         // Threshold and connect fields as written
         if (wr_pulse &&
             wr_addr_hold_reg == sbc_pkg::comparator3_threshold_and_calibration_addr) begin
            cal_reg[7:3] <= wr_data_hold_reg[7:3];
         end
         cal_reg[sbc_pkg::amp_one_cal_bit] <=
            (cal_reg[sbc_pkg::amp_one_cal_bit] && !done_edge[sbc_pkg::done_amp_one]) ||
            (wr_pulse && wr_addr_hold_reg == sbc_pkg::comparator3_threshold_and_calibration_addr
             && wr_data_hold_reg[sbc_pkg::amp_one_cal_bit]);
         cal_reg[sbc_pkg::amp_two_cal_bit] <=
            (cal_reg[sbc_pkg::amp_two_cal_bit] && !done_edge[sbc_pkg::done_amp_two]) ||
            (wr_pulse && wr_addr_hold_reg == sbc_pkg::comparator3_threshold_and_calibration_addr
             && wr_data_hold_reg[sbc_pkg::amp_two_cal_bit]);
         cal_reg[sbc_pkg::amp_three_cal_bit] <=
            (cal_reg[sbc_pkg::amp_three_cal_bit] && !cal3_done) ||
            (wr_pulse && wr_addr_hold_reg == sbc_pkg::comparator3_threshold_and_calibration_addr
             && wr_data_hold_reg[sbc_pkg::amp_three_cal_bit]);
         if (wr_pulse && wr_addr_hold_reg == sbc_pkg::comparator3_threshold_and_calibration_addr
             && wr_data_hold_reg[sbc_pkg::amp_three_cal_bit]
             && !cal_reg[sbc_pkg::amp_three_cal_bit]) begin
            cal3_is_bemf_reg <= bemf_s2_reg;
         end
      end
   end

   // Mux, dead time and unlock register, reserved bits stored as written
   always_ff @(posedge clock) begin
      if (reset) begin
         mux_reg <= sbc_pkg::mux_deadtime_unlock_control_rst;
      end else if (wr_pulse && wr_addr_hold_reg == sbc_pkg::mux_deadtime_unlock_control_addr) begin
         mux_reg <= wr_data_hold_reg;
      end
   end

   // Locked register
   always_ff @(posedge clock) begin
      if (reset) begin
         locked_reg <= sbc_pkg::locked_sense_control_rst;
      end else if (wr_pulse && wr_addr_hold_reg == sbc_pkg::locked_sense_control_addr
                   && mux_reg[sbc_pkg::unlock_bit]) begin
         locked_reg <= wr_data_hold_reg;
      end else if (cal_reg[sbc_pkg::amp_three_cal_bit] && cal3_is_bemf_reg
                   && done_edge[sbc_pkg::done_backemf]) begin
         locked_reg[sbc_pkg::offset_source_bit] <= 1'b0;
      end
   end

   // ==========================================
   // Read side
   always_comb begin
      if (rd_addr_hold_reg == sbc_pkg::comparator12_threshold_addr) begin
         rd_mux = comp12_reg;
      end else if (rd_addr_hold_reg == sbc_pkg::comparator3_threshold_and_calibration_addr) begin
         rd_mux = cal_reg;
      end else if (rd_addr_hold_reg == sbc_pkg::mux_deadtime_unlock_control_addr) begin
         rd_mux = mux_reg;
      end else if (rd_addr_hold_reg == sbc_pkg::locked_sense_control_addr) begin
         rd_mux = locked_reg;
      end else begin
         rd_mux = 8'h00;
      end
   end

   // Answer held stable, then announced by toggle
   always_ff @(posedge clock) begin
      if (reset) begin
         rd_data_hold_reg <= 8'h00;
         rd_ack_toggle_reg <= 1'b0;
      end else if (rd_pulse) begin
         rd_data_hold_reg <= rd_mux;
         rd_ack_toggle_reg <= ~rd_ack_toggle_reg;
      end
   end

   // ==========================================
   // Outputs to the analog blocks
   always_ff @(posedge clock) begin
      if (reset) begin
         comparator_cfg <= '0;
      end else begin
         comparator_cfg.comp_one_threshold_code <= comp12_reg[sbc_pkg::comp_one_code_lsb +: 4];
         comparator_cfg.comp_one_enable <= comp12_reg[sbc_pkg::comp_one_code_lsb +: 4] != 4'h0;
         comparator_cfg.comp_two_threshold_code <= comp12_reg[sbc_pkg::comp_two_code_lsb +: 4];
         comparator_cfg.comp_two_enable <= comp12_reg[sbc_pkg::comp_two_code_lsb +: 4] != 4'h0;
         comparator_cfg.comp_three_threshold_code <= cal_reg[sbc_pkg::comp_three_code_lsb +: 4];
         comparator_cfg.comp_three_enable <= cal_reg[sbc_pkg::comp_three_code_lsb +: 4] != 4'h0;
      end
   end

   // Calibration drive
   always_ff @(posedge clock) begin
      if (reset) begin
         calibration_cfg <= '0;
      end else begin
         calibration_cfg.calibration_input_connect <= cal_reg[sbc_pkg::cal_connect_bit];
         calibration_cfg.amp_one_calibrate <= cal_reg[sbc_pkg::amp_one_cal_bit];
         calibration_cfg.amp_two_calibrate <= cal_reg[sbc_pkg::amp_two_cal_bit];
         calibration_cfg.amp_three_calibrate <=
            cal_reg[sbc_pkg::amp_three_cal_bit] && !cal3_is_bemf_reg;
         calibration_cfg.backemf_calibrate <=
            cal_reg[sbc_pkg::amp_three_cal_bit] && cal3_is_bemf_reg;
      end
   end

   // Dead time, override and offset source
   always_ff @(posedge clock) begin
      if (reset) begin
         adaptive_deadtime_disable <= 1'b0;
         backemf_offset_source <= 1'b1;
         gate_override_enable <= 1'b0;
      end else begin
         adaptive_deadtime_disable <= mux_reg[sbc_pkg::deadtime_disable_bit];
         backemf_offset_source <= locked_reg[sbc_pkg::offset_source_bit];
         gate_override_enable <= locked_reg[sbc_pkg::override_bit];
      end
   end

   // Analog output mux decode
   always_ff @(posedge clock) begin
      if (reset) begin
         mux_route <= '0;
      end else begin
         mux_route <= '0;
         case (mux_reg[sbc_pkg::mux_sel_lsb +: 3])
            sbc_pkg::mux_gnd: mux_route.gnd_pulldown <= 1'b1;
            sbc_pkg::mux_temp: mux_route.temp_monitor <= 1'b1;
            sbc_pkg::mux_amp1: mux_route.amp_one <= 1'b1;
            sbc_pkg::mux_amp2: mux_route.amp_two <= 1'b1;
            sbc_pkg::mux_amp3_res: begin
               mux_route.backemf_series_res <= bemf_s2_reg;
               mux_route.amp_three_series_res <= !bemf_s2_reg;
            end
            sbc_pkg::mux_amp3_direct: begin
               mux_route.backemf_direct <= bemf_s2_reg;
               mux_route.amp_three_direct <= !bemf_s2_reg;
            end
            default: mux_route.gnd_pulldown <= 1'b0;
         endcase
      end
   end

endmodule

`default_nettype wire

// ### tb/sbc_props.sv
`timescale 1ns/1ns
`default_nettype none

// ==========================================
// Port checker for the sense control registers
module sbc_props (
   input wire logic clock,
   input wire logic reset,
   input wire logic link_cs_n,
   input wire logic backemf_sensing_enable,
   input wire logic [3:0] calibration_done,
   input wire sbc_pkg::sbc_comparator_t comparator_cfg,
   input wire sbc_pkg::sbc_calibration_t calibration_cfg,
   input wire logic adaptive_deadtime_disable,
   input wire sbc_pkg::sbc_mux_route_t mux_route,
   input wire logic backemf_offset_source
);
   // Everything is judged on the system clock
   default clocking @(posedge clock);
   endclocking
   default disable iff (reset);

   a_comp_one_gate: assert property (
      comparator_cfg.comp_one_enable == (comparator_cfg.comp_one_threshold_code != 4'h0))
      else $error("comparator one enable does not follow its code");
   a_comp_two_gate: assert property (
      comparator_cfg.comp_two_enable == (comparator_cfg.comp_two_threshold_code != 4'h0))
      else $error("comparator two enable does not follow its code");
   a_comp_three_gate: assert property (
      comparator_cfg.comp_three_enable == (comparator_cfg.comp_three_threshold_code != 4'h0))
      else $error("comparator three enable does not follow its code");
   a_route_one_hot: assert property ($onehot0(mux_route))
      else $error("more than one analog route active");
   a_amp_route_off: assert property (
      backemf_sensing_enable [*5] |-> !mux_route.amp_three_direct && !mux_route.amp_three_series_res)
      else $error("amp three routed while back-emf sensing on");
   a_bemf_route_off: assert property (
      !backemf_sensing_enable [*5] |-> !mux_route.backemf_direct && !mux_route.backemf_series_res)
      else $error("back-emf routed while sensing off");
   a_amp1_self_clear: assert property (
      $rose(calibration_done[0]) |-> ##[1:8] !calibration_cfg.amp_one_calibrate)
      else $error("amp one request not cleared after done");
   a_amp2_self_clear: assert property (
      $rose(calibration_done[1]) |-> ##[1:8] !calibration_cfg.amp_two_calibrate)
      else $error("amp two request not cleared after done");
   a_amp3_target: assert property (
      $rose(calibration_cfg.amp_three_calibrate) |-> !$past(backemf_sensing_enable, 4))
      else $error("amp three calibration with back-emf on");
   a_bemf_target: assert property (
      $rose(calibration_cfg.backemf_calibrate) |-> $past(backemf_sensing_enable, 4))
      else $error("back-emf calibration with sensing off");
   a_bemf_self_clear: assert property (
      $rose(calibration_done[3]) ##0 calibration_cfg.backemf_calibrate
      |-> ##[1:8] !calibration_cfg.backemf_calibrate && !backemf_offset_source)
      else $error("back-emf done did not clear request and offset source");
   a_cal_held: assert property (
      $fell(calibration_cfg.amp_one_calibrate) |-> calibration_done[0])
      else $error("amp one request dropped before done");
   a_cfg_quiet: assert property (
      link_cs_n [*8] |-> $stable({calibration_cfg.calibration_input_connect,
      adaptive_deadtime_disable}))
      else $error("control level changed without a frame");
endmodule

bind sbc_sense_block_control_regs sbc_props u_props (
   .clock(clock), .reset(reset), .link_cs_n(link_cs_n),
   .backemf_sensing_enable(backemf_sensing_enable), .calibration_done(calibration_done),
   .comparator_cfg(comparator_cfg), .calibration_cfg(calibration_cfg),
   .adaptive_deadtime_disable(adaptive_deadtime_disable), .mux_route(mux_route),
   .backemf_offset_source(backemf_offset_source)
);

`default_nettype wire

// ### tb/sbc_spi_host.sv
`timescale 1ns/1ns
`default_nettype none

// ==========================================
// Serial host model, mode 0, link clock 160 ns
module sbc_spi_host (
   output logic link_sclk,
   output logic link_cs_n,
   output logic link_mosi,
   input wire logic link_miso
);
   // Idle lines, clock stands low between frames
   initial begin
      link_sclk = 1'b0;
      link_cs_n <= 1'b1; // Late in time zero so the counter clear is seen
      link_mosi = 1'b0;
   end

   // One frame MSB first; reply bits taken at rising edges 16 onward
   task automatic xfer(input logic [15:0] w, input int n, output logic [7:0] q);
      q = 8'h00;
      #37;
      link_cs_n = 1'b0;
      for (int i = 0; i < n; i++) begin
         link_mosi = (i < 16) ? w[15 - i] : ~link_mosi;
         #80;
         link_sclk = 1'b1;
         if (i >= 16) begin
            q = {q[6:0], link_miso};
         end
         #80;
         link_sclk = 1'b0;
      end
      link_cs_n = 1'b1;
      link_mosi = ~link_mosi; // Released data line must not look stable
      #160;
   endtask
endmodule

`default_nettype wire

// ### tb/sbc_sense_block_control_regs_tb.sv
`timescale 1ns/1ns
`default_nettype none

// ==========================================
// Bench for the sense control registers
module sbc_sense_block_control_regs_tb;
   logic clock, reset, backemf_sensing_enable;
   logic [3:0] calibration_done;
   wire logic link_sclk, link_cs_n, link_mosi;
   logic link_miso, adaptive_deadtime_disable, backemf_offset_source, gate_override_enable;
   sbc_pkg::sbc_comparator_t comparator_cfg;
   sbc_pkg::sbc_calibration_t calibration_cfg;
   sbc_pkg::sbc_mux_route_t mux_route;
   int miscompares = 0;
   int check_count = 0;
   logic [7:0] cv [3] = '{8'h0f, 8'h10, 8'hf1};

   sbc_sense_block_control_regs DUT (
      .clock(clock), .reset(reset), .link_sclk(link_sclk), .link_cs_n(link_cs_n),
      .link_mosi(link_mosi), .link_miso(link_miso),
      .backemf_sensing_enable(backemf_sensing_enable), .calibration_done(calibration_done),
      .comparator_cfg(comparator_cfg), .calibration_cfg(calibration_cfg),
      .adaptive_deadtime_disable(adaptive_deadtime_disable), .mux_route(mux_route),
      .backemf_offset_source(backemf_offset_source),
      .gate_override_enable(gate_override_enable));

   sbc_spi_host u_host (.link_sclk(link_sclk), .link_cs_n(link_cs_n),
      .link_mosi(link_mosi), .link_miso(link_miso));

   // System clock
   always #5 clock = ~clock;

   // Verdict and end of run
   task automatic test_done();
      if (miscompares == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      logic [7:0] q;
      u_host.xfer({1'b0, a, d}, 16, q);
      repeat (8) @(posedge clock);
   endtask

   task automatic rd(input logic [6:0] a, input logic [7:0] e);
      logic [7:0] q;
      u_host.xfer({1'b1, a, 8'h00}, 24, q);
      repeat (2) @(posedge clock);
      chk(16'(q), 16'(e));
   endtask

   // Bounded wait for the calibration outputs
   task automatic wfor(input logic [4:0] e);
      int k;
      k = 0;
      while (calibration_cfg !== e && k < 20) begin
         @(posedge clock);
         k++;
      end
      chk(16'(calibration_cfg), 16'(e));
      if (k >= 20) begin
         test_done();
      end
   endtask

   // Analog side reports one calibration finished
   task automatic fin(input int b, input logic [4:0] e);
      @(posedge clock);
      calibration_done[b] <= 1'b1;
      wfor(e);
      @(posedge clock);
      calibration_done[b] <= 1'b0;
      repeat (4) @(posedge clock);
   endtask

   task automatic setb(input logic v);
      @(posedge clock);
      backemf_sensing_enable <= v;
      repeat (6) @(posedge clock);
   endtask

   function automatic sbc_pkg::sbc_comparator_t cmp(input logic [7:0] a, input logic [3:0] c);
      return {a[7:4] != 4'h0, a[7:4], a[3:0] != 4'h0, a[3:0], c != 4'h0, c};
   endfunction

   function automatic sbc_pkg::sbc_mux_route_t route(input logic [2:0] c, input logic b);
      return {c == 3'h0, c == 3'h2, c == 3'h5, c == 3'h6, !b && c == 3'h4,
         !b && c == 3'h7, b && c == 3'h4, b && c == 3'h7};
   endfunction

   // Main sequence
   initial begin
      clock = 1'b0;
      reset <= 1'b1; // Late in time zero so every reset edge is seen
      backemf_sensing_enable = 1'b0;
      calibration_done = 4'h0;
      repeat (6) @(posedge clock);
      reset <= 1'b0;
      repeat (3) @(posedge clock);
      rd(7'h0f, 8'h88);
      rd(7'h10, 8'h80);
      rd(7'h11, 8'h00);
      rd(7'h12, 8'h40);
      rd(7'h13, 8'h00);
      chk(16'(comparator_cfg), 16'(cmp(8'h88, 4'h8)));
      chk(16'(mux_route), 16'(route(3'h0, 1'b0)));
      // Threshold codes at zero, one step and full scale
      for (int i = 0; i < 3; i++) begin
         wr(7'h0f, cv[i]);
         wr(7'h10, {cv[i][3:0], i[0], 3'h0});
         chk(16'(comparator_cfg), 16'(cmp(cv[i], cv[i][3:0])));
         chk(16'(calibration_cfg), 16'({i[0], 4'h0}));
         rd(7'h0f, cv[i]);
      end
      // Every mux code with back-emf sensing off and on, reserved bits zero
      for (int b = 0; b < 2; b++) begin
         setb(b[0]);
         for (int c = 0; c < 8; c++) begin
            wr(7'h11, {c[0], 4'h0, c[2:0]});
            chk(16'(mux_route), 16'(route(c[2:0], b[0])));
            chk(16'(adaptive_deadtime_disable), 16'(c[0]));
         end
      end
      rd(7'h11, 8'h87);
      // Locked register
      wr(7'h12, 8'h41);
      rd(7'h12, 8'h40);
      wr(7'h11, 8'h20);
      wr(7'h12, 8'h41);
      chk(16'({backemf_offset_source, gate_override_enable}), 16'h0003);
      wr(7'h11, 8'h00);
      wr(7'h12, 8'h00);
      rd(7'h12, 8'h41);
      // Calibration requests and their completion
      setb(1'b0);
      wr(7'h10, 8'h86);
      wfor(5'h0c);
      wr(7'h10, 8'h80);
      rd(7'h10, 8'h86);
      fin(0, 5'h04);
      fin(1, 5'h00);
      rd(7'h10, 8'h80);
      wr(7'h10, 8'h81);
      wfor(5'h02);
      fin(2, 5'h00);
      setb(1'b1);
      wr(7'h10, 8'h81);
      wfor(5'h01);
      fin(3, 5'h00);
      chk(16'(backemf_offset_source), 16'h0000);
      rd(7'h12, 8'h01);
      test_done();
   end
endmodule

`default_nettype wire
